// >>> hw/plcms_pkg.sv
package plcms_pkg;
    localparam int NUM_INPUTS = 7;
    localparam int FUNC_W = 8;
    localparam logic [7:0] FUNC_SEL_LOW = 8'h33;
    localparam logic [7:0] FUNC_SEL_HIGH = 8'h34;
    localparam logic [1:0] KEY_DISABLED = 2'h1;
    localparam logic [1:0] KEY_RUN = 2'h2;
    localparam logic [1:0] KEY_STOP = 2'h3;
    localparam int OUT_RELAY_BIT = 0;
    localparam int OUT_DO1_BIT = 3;
    localparam int OUT_DO2_BIT = 4;
    localparam int PROG_OUT_W = 16;
    localparam int PROG_IN_W = 16;
    localparam int AO_OWN_BIT = 0;
    typedef enum logic [1:0] {
        PLCMS_DISABLED,
        PLCMS_RUN,
        PLCMS_STOP
    } plcms_mode_type;
endpackage

// >>> hw/plcms_sel_decode.sv
`timescale 1ns/1ps
`default_nettype none
// finds terminals configured as mode-select bits and samples their level
module plcms_sel_decode #(
    parameter int N = plcms_pkg::NUM_INPUTS
) (
    input wire logic [N*plcms_pkg::FUNC_W-1:0] func_codes,
    input wire logic [N-1:0] levels,
    output logic any_low,
    output logic any_high,
    output logic low_on,
    output logic high_on
);
    // or-reduce over terminals carrying each select function
    always_comb begin
        any_low = 1'b0;
        any_high = 1'b0;
        low_on = 1'b0;
        high_on = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (func_codes[i*plcms_pkg::FUNC_W +: plcms_pkg::FUNC_W] ==
                plcms_pkg::FUNC_SEL_LOW) begin
                any_low = 1'b1;
                low_on = low_on | levels[i];
            end
            if (func_codes[i*plcms_pkg::FUNC_W +: plcms_pkg::FUNC_W] ==
                plcms_pkg::FUNC_SEL_HIGH) begin
                any_high = 1'b1;
                high_on = high_on | levels[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/plcms_top.sv
`timescale 1ns/1ps
`default_nettype none
module plcms_top #(
    parameter int N = plcms_pkg::NUM_INPUTS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [N-1:0] multifunction_inputs,
    input wire logic [N*plcms_pkg::FUNC_W-1:0] input_func_codes,
    input wire logic [1:0] keypad_choice,
    input wire logic keypad_enter,
    input wire logic serial_start,
    input wire logic serial_stop,
    input wire logic transfer_busy,
    input wire logic [plcms_pkg::PROG_IN_W-1:0] prog_in_used,
    input wire logic [plcms_pkg::PROG_IN_W-1:0] prog_in_write,
    input wire logic [plcms_pkg::PROG_OUT_W-1:0] prog_out_used,
    input wire logic [plcms_pkg::PROG_OUT_W-1:0] prog_out_value,
    input wire logic prog_ao_used,
    input wire logic [15:0] prog_ao_value,
    input wire logic normal_relay,
    input wire logic normal_do1,
    input wire logic normal_do2,
    input wire logic [15:0] normal_ao_value,
    output logic [1:0] ctrl_mode,
    output logic ctrl_mode_disabled,
    output logic ctrl_mode_run,
    output logic ctrl_mode_stop,
    output logic prog_start,
    output logic prog_stop,
    output logic [N-1:0] prog_inputs,
    output logic [N-1:0] mi_function_enable,
    output logic relay_contacts,
    output logic digital_output_one,
    output logic digital_output_two,
    output logic [15:0] analog_output_terminal,
    output logic [15:0] input_ownership_monitor,
    output logic [15:0] output_ownership_monitor,
    output logic [15:0] analog_ownership_monitor
);
    initial begin
        if (N < 1 || N > plcms_pkg::PROG_IN_W) begin
            $error("plcms_top: input count out of range");
        end
    end

    // two-stage synchroniser for the terminal pins
    logic [N-1:0] pin_meta;
    logic [N-1:0] pin_sync;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= multifunction_inputs;
            pin_sync <= pin_meta;
        end
    end

    logic any_low;
    logic any_high;
    logic low_on;
    logic high_on;
    plcms_sel_decode #(.N(N)) u_dec (
        .func_codes(input_func_codes),
        .levels(pin_sync),
        .any_low(any_low),
        .any_high(any_high),
        .low_on(low_on),
        .high_on(high_on)
    );

    // mode selection: transfer, then terminals, then keypad
    plcms_pkg::plcms_mode_type mode;
    plcms_pkg::plcms_mode_type next_mode;
    logic key_run_evt;
    logic key_stop_evt;
    always_comb begin
        next_mode = mode;
        key_run_evt = 1'b0;
        key_stop_evt = 1'b0;
        if (transfer_busy) begin
            next_mode = plcms_pkg::PLCMS_DISABLED;
        end else if (any_low || any_high) begin
            unique case ({high_on, low_on})
                2'h0: next_mode = plcms_pkg::PLCMS_DISABLED;
                2'h1: next_mode = plcms_pkg::PLCMS_RUN;
                2'h2: next_mode = plcms_pkg::PLCMS_STOP;
                2'h3: next_mode = mode;
            endcase
        end else if (keypad_enter) begin
            case (keypad_choice)
                plcms_pkg::KEY_DISABLED: next_mode = plcms_pkg::PLCMS_DISABLED;
                plcms_pkg::KEY_RUN: begin
                    next_mode = plcms_pkg::PLCMS_RUN;
                    key_run_evt = 1'b1;
                end
                plcms_pkg::KEY_STOP: begin
                    next_mode = plcms_pkg::PLCMS_STOP;
                    key_stop_evt = 1'b1;
                end
                default: next_mode = mode;
            endcase
        end
    end

    // mode register and decoded mode flags
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode <= plcms_pkg::PLCMS_DISABLED;
            ctrl_mode <= 2'h0;
            ctrl_mode_disabled <= 1'b1;
            ctrl_mode_run <= 1'b0;
            ctrl_mode_stop <= 1'b0;
        end else begin
            mode <= next_mode;
            ctrl_mode <= next_mode;
            ctrl_mode_disabled <= next_mode == plcms_pkg::PLCMS_DISABLED;
            ctrl_mode_run <= next_mode == plcms_pkg::PLCMS_RUN;
            ctrl_mode_stop <= next_mode == plcms_pkg::PLCMS_STOP;
        end
    end

    // one-cycle start/stop events from keypad or serial link
    logic active_mode;
    assign active_mode = (mode != plcms_pkg::PLCMS_DISABLED) && !transfer_busy;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prog_start <= 1'b0;
            prog_stop <= 1'b0;
        end else begin
            prog_start <= key_run_evt || (active_mode && serial_start);
            prog_stop <= key_stop_evt || (active_mode && serial_stop);
        end
    end

    // input terminal ownership and values seen by the program
    logic [N-1:0] in_owned;
    assign in_owned = prog_in_used[N-1:0] | prog_in_write[N-1:0];
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prog_inputs <= '0;
            mi_function_enable <= '1;
        end else begin
            prog_inputs <= pin_sync;
            mi_function_enable <= active_mode ? ~in_owned : '1;
        end
    end

    // output steering between program and normal functions
    logic run_or_stop;
    assign run_or_stop = mode != plcms_pkg::PLCMS_DISABLED;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            relay_contacts <= 1'b0;
            digital_output_one <= 1'b0;
            digital_output_two <= 1'b0;
        end else begin
            relay_contacts <= (run_or_stop && prog_out_used[plcms_pkg::OUT_RELAY_BIT])
                ? prog_out_value[plcms_pkg::OUT_RELAY_BIT] : normal_relay;
            digital_output_one <= (run_or_stop && prog_out_used[plcms_pkg::OUT_DO1_BIT])
                ? prog_out_value[plcms_pkg::OUT_DO1_BIT] : normal_do1;
            digital_output_two <= (run_or_stop && prog_out_used[plcms_pkg::OUT_DO2_BIT])
                ? prog_out_value[plcms_pkg::OUT_DO2_BIT] : normal_do2;
        end
    end

    // analog output handover
    logic ao_owned;
    assign ao_owned = run_or_stop && prog_ao_used;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            analog_output_terminal <= 16'h0000;
        end else begin
            analog_output_terminal <= ao_owned ? prog_ao_value : normal_ao_value;
        end
    end

    // ownership monitors
    logic [15:0] in_mon;
    logic [15:0] out_mon;
    always_comb begin
        in_mon = 16'h0000;
        in_mon[N-1:0] = run_or_stop ? in_owned : '0;
        out_mon = 16'h0000;
        out_mon[0] = run_or_stop && prog_out_used[plcms_pkg::OUT_RELAY_BIT];
        out_mon[1] = run_or_stop && prog_out_used[plcms_pkg::OUT_DO1_BIT];
        out_mon[2] = run_or_stop && prog_out_used[plcms_pkg::OUT_DO2_BIT];
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            input_ownership_monitor <= 16'h0000;
            output_ownership_monitor <= 16'h0000;
            analog_ownership_monitor <= 16'h0000;
        end else begin
            input_ownership_monitor <= in_mon;
            output_ownership_monitor <= out_mon;
            analog_ownership_monitor <= {15'h0000, ao_owned};
        end
    end

    // checks
    a_transfer_disables: assert property (@(posedge clock) disable iff (sys_rst)
        transfer_busy |=> ctrl_mode_disabled) else $error("mode not disabled in transfer");
    a_terms_run: assert property (@(posedge clock) disable iff (sys_rst)
        (!transfer_busy && (any_low || any_high) && low_on && !high_on) |=> ctrl_mode_run)
        else $error("terminal run not taken");
    a_terms_stop: assert property (@(posedge clock) disable iff (sys_rst)
        (!transfer_busy && (any_low || any_high) && !low_on && high_on) |=> ctrl_mode_stop)
        else $error("terminal stop not taken");
    a_terms_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (!transfer_busy && low_on && high_on) |=> $stable(ctrl_mode))
        else $error("both on did not hold");
    a_keypad_ignored: assert property (@(posedge clock) disable iff (sys_rst)
        (!transfer_busy && (any_low || any_high) && !serial_start && !serial_stop)
        |=> !prog_start && !prog_stop)
        else $error("keypad event while terminals own mode");
    a_start_single: assert property (@(posedge clock) disable iff (sys_rst)
        (keypad_enter && keypad_choice == plcms_pkg::KEY_RUN && !transfer_busy
         && !any_low && !any_high) |=> prog_start) else $error("no start pulse");
    a_stop_single: assert property (@(posedge clock) disable iff (sys_rst)
        (keypad_enter && keypad_choice == plcms_pkg::KEY_STOP && !transfer_busy
         && !any_low && !any_high) |=> prog_stop) else $error("no stop pulse");
    a_relay_follows: assert property (@(posedge clock) disable iff (sys_rst)
        (run_or_stop && prog_out_used[0]) |=> relay_contacts == $past(prog_out_value[0]))
        else $error("relay not driven by program");
    a_ao_monitor: assert property (@(posedge clock) disable iff (sys_rst)
        ##1 analog_ownership_monitor[0] == $past(ao_owned))
        else $error("analog monitor wrong");
    c_keypad_run: cover property (@(posedge clock) ctrl_mode_run && prog_start);
    c_terms_stop: cover property (@(posedge clock) any_high && ctrl_mode_stop);
    c_transfer: cover property (@(posedge clock) transfer_busy ##1 ctrl_mode_disabled);
    c_ao_owned: cover property (@(posedge clock) analog_ownership_monitor[0]);
endmodule
`default_nettype wire

// >>> bench/plcms_panel.sv
`timescale 1ns/1ps
`default_nettype none
// keypad and terminal pins in front of the mode selector
module plcms_panel (
    input wire logic clock,
    output logic [1:0] keypad_choice,
    output logic keypad_enter,
    output logic [6:0] multifunction_inputs
);
    initial begin
        keypad_choice = 2'h0;
        keypad_enter = 1'b0;
        multifunction_inputs = 7'h00;
    end
    // one enter pulse, choice scrambled once released
    task automatic press(input logic [1:0] c);
        @(negedge clock);
        keypad_choice = c;
        keypad_enter = 1'b1;
        @(negedge clock);
        keypad_enter = 1'b0;
        keypad_choice = ~c;
    endtask
    task automatic set_pins(input logic [6:0] v);
        @(negedge clock);
        multifunction_inputs = v;
    endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic ss = 1'b0, sp = 1'b0, busy = 1'b0, ao_used = 1'b0;
    logic n_relay = 1'b0, n_do1 = 1'b0, n_do2 = 1'b1;
    logic [55:0] codes = 56'h0;
    logic [15:0] in_used = 16'h0, in_wr = 16'h0, out_used = 16'h0, out_val = 16'h0;
    logic [15:0] ao_val = 16'h1234, n_ao = 16'hABCD;
    logic [1:0] kc, mode;
    logic ke, dis, run, stp, pst, psp, rly, d1, d2;
    logic [6:0] pins, pin_q, mi_en;
    logic [15:0] ao, imon, omon, amon;
    int n_fail = 0;
    int cmp_count = 0;
    logic [1:0] pv[5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
    logic [6:0] pp[5] = '{7'h01, 7'h03, 7'h02, 7'h03, 7'h00};
    logic [1:0] pm[5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
    logic [1:0] ks[3] = '{2'h2, 2'h3, 2'h1};
    plcms_panel plcms_panel_i (.clock(clock), .keypad_choice(kc), .keypad_enter(ke),
        .multifunction_inputs(pins));
    plcms_top plcms_top_i (.clock(clock), .sys_rst(sys_rst), .multifunction_inputs(pins),
        .input_func_codes(codes), .keypad_choice(kc), .keypad_enter(ke), .serial_start(ss),
        .serial_stop(sp), .transfer_busy(busy), .prog_in_used(in_used), .prog_in_write(in_wr),
        .prog_out_used(out_used), .prog_out_value(out_val), .prog_ao_used(ao_used),
        .prog_ao_value(ao_val), .normal_relay(n_relay), .normal_do1(n_do1), .normal_do2(n_do2),
        .normal_ao_value(n_ao), .ctrl_mode(mode), .ctrl_mode_disabled(dis), .ctrl_mode_run(run),
        .ctrl_mode_stop(stp), .prog_start(pst), .prog_stop(psp), .prog_inputs(pin_q),
        .mi_function_enable(mi_en), .relay_contacts(rly), .digital_output_one(d1),
        .digital_output_two(d2), .analog_output_terminal(ao), .input_ownership_monitor(imon),
        .output_ownership_monitor(omon), .analog_ownership_monitor(amon));
    // free-running clock, 4 ns period
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
    initial begin
        tick(20);
        sys_rst = 1'b0;
        chk({dis, run, stp, mi_en}, {3'h4, 7'h7F});
        chk(omon | imon | amon, 16'h0);
        // keypad choices and their one-shot pulses
        foreach (ks[i]) begin
            plcms_panel_i.press(ks[i]);
            chk(mode, ks[i] - 2'h1);
            chk({dis, run, stp}, {ks[i] == 2'h1, ks[i] == 2'h2, ks[i] == 2'h3});
            chk({pst, psp}, {ks[i] == 2'h2, ks[i] == 2'h3});
            tick(1);
            chk({pst, psp}, 2'h0);
        end
        // serial stop honoured in run
        plcms_panel_i.press(2'h2);
        tick(1);
        sp = 1'b1;
        tick(1);
        sp = 1'b0;
        chk(psp, 1'b1);
        // serial start honoured in stop
        plcms_panel_i.press(2'h3);
        ss = 1'b1;
        tick(1);
        ss = 1'b0;
        chk({pst, psp}, 2'h2);
        plcms_panel_i.press(2'h1);
        ss = 1'b1;
        tick(1);
        ss = 1'b0;
        chk(pst, 1'b0);
        // terminal ownership in run mode
        plcms_panel_i.press(2'h2);
        out_used = 16'h0019;
        out_val = 16'h0009;
        ao_used = 1'b1;
        in_used = 16'h0004;
        in_wr = 16'h0010;
        plcms_panel_i.set_pins(7'h55);
        tick(4);
        chk({rly, d1, d2}, 3'h6);
        chk(omon, 16'h0007);
        chk(imon, 16'h0014);
        chk(mi_en, 7'h6B);
        chk(pin_q, 7'h55);
        chk(ao, 16'h1234);
        chk(amon, 16'h0001);
        ao_used = 1'b0;
        tick(2);
        chk({ao, amon}, {16'hABCD, 16'h0});
        plcms_panel_i.press(2'h1);
        tick(1);
        chk({rly, d1, d2, mi_en}, {3'h1, 7'h7F});
        // normal drives pass through while disabled
        n_relay = 1'b1;
        n_do1 = 1'b1;
        n_do2 = 1'b0;
        n_ao = 16'h5A5A;
        tick(2);
        chk({rly, d1, d2}, 3'h6);
        chk(ao, 16'h5A5A);
        in_used = 16'h0;
        in_wr = 16'h0;
        // select terminals override the keypad
        codes = {40'h0, plcms_pkg::FUNC_SEL_HIGH, plcms_pkg::FUNC_SEL_LOW};
        foreach (pp[i]) begin
            plcms_panel_i.set_pins(pp[i]);
            tick(4);
            chk(mode, pm[i]);
            plcms_panel_i.press(2'h3 - pv[i]);
            chk({pst, psp}, 2'h0);
            chk(mode, pm[i]);
        end
        // transfer in progress holds disabled
        codes = 56'h0;
        plcms_panel_i.press(2'h2);
        busy = 1'b1;
        tick(2);
        chk(dis, 1'b1);
        plcms_panel_i.press(2'h2);
        chk({dis, pst}, 2'h2);
        busy = 1'b0;
        give_verdict();
    end
endmodule
`default_nettype wire
